// File: hw/pmrc_top.sv
`timescale 1ns/1ps
module pmrc_top #(
    parameter int EXT_LINES = pmrc_pkg::EXT_LINES,
    parameter int DS_OTHER = pmrc_pkg::DS_OTHER_SRC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_sleep_req,
    input wire logic i_deep_req,
    input wire logic i_stby_req,
    input wire logic i_irq_any,
    input wire logic [EXT_LINES-1:0] i_ext_lines,
    input wire logic [DS_OTHER-1:0] i_ds_wake_src,
    input wire logic i_external_reset_pin,
    input wire logic i_rtc_wake,
    input wire logic i_independent_watchdog,
    input wire logic i_wakeup_pin,
    input wire logic i_clock_monitor_lock_event,
    input wire logic i_supply_low,
    input wire logic i_low_voltage_detector,
    input wire logic i_soft_reset,
    input wire logic i_rc_osc_64m_stable,
    input wire logic i_boot_pin,
    input wire logic [1:0] i_boot_mode,
    input wire logic [31:0] i_boot_address_values0,
    input wire logic [31:0] i_boot_address_values1,
    output logic o_core_clk_en,
    output logic o_periph_clk_en,
    output logic o_core_domain_clk_en,
    output logic o_low_power_rc_4m_en,
    output logic o_rc_osc_64m_en,
    output logic o_high_speed_crystal_en,
    output logic o_pll_en,
    output logic o_regulator_en,
    output logic o_core_domain_pwr,
    output logic o_retain,
    output logic o_clk_src_force,
    output logic [1:0] o_clk_src,
    output logic o_sys_rst,
    output logic o_lvd_irq,
    output logic [31:0] o_boot_addr,
    output logic [1:0] o_boot_mode,
    output logic [2:0] o_mode
);
    // ****************************************
    // state and wake decode
    // ****************************************
    typedef enum logic [2:0] {PMRC_RUN, PMRC_SLEEP, PMRC_DEEP, PMRC_WAIT_RC, PMRC_STBY} pmrc_st_t;
    pmrc_st_t st;
    pmrc_st_t next_st;
    pmrc_st_t next_mode;
    logic ds_wake;
    logic sb_wake;
    logic rst_req;
    logic rst_out;
    logic gate_en_raw;
    logic gate_en;
    logic lvd_q;
    logic next_core_clk;
    logic next_periph;
    logic clk_tree_on;
    logic core_powered;
    logic next_retain;
    logic next_force;
    logic next_lvd_irq;
    logic [31:0] boot_pick;
    logic [31:0] next_boot_addr;

    // mode decodes shared by the gate and the outputs
    function automatic logic core_runs(input pmrc_st_t s);
        return s == PMRC_RUN;
    endfunction
    // oscillators and the core-domain clock tree die in deep-sleep and standby
    function automatic logic osc_alive(input pmrc_st_t s);
        return !(s == PMRC_DEEP || s == PMRC_STBY);
    endfunction
    // only standby removes the regulator and the core-domain supply
    function automatic logic domain_powered(input pmrc_st_t s);
        return s != PMRC_STBY;
    endfunction

    // any wake line routed through the external interrupt unit
    assign ds_wake = (|i_ext_lines) || (|i_ds_wake_src);
    assign sb_wake = i_external_reset_pin || i_rtc_wake || i_independent_watchdog
        || i_wakeup_pin || i_clock_monitor_lock_event;
    // standby exit restarts from reset; supervisor low supply always forces reset
    assign rst_req = i_supply_low || i_soft_reset || i_external_reset_pin
        || (st == PMRC_STBY && sb_wake);
    // a standing reset pulls the mode back to run, so no output shows a mode that the
    // register is leaving
    assign next_mode = rst_out ? PMRC_RUN : next_st;

    // next mode; deep-sleep exit waits for the RC
    always_comb
    begin
        next_st = st;
        unique case (st)
            PMRC_RUN:
            begin
                if (i_stby_req)
                    next_st = PMRC_STBY;
                else if (i_deep_req)
                    next_st = PMRC_DEEP;
                else if (i_sleep_req)
                    next_st = PMRC_SLEEP;
            end
            PMRC_SLEEP:
                if (i_irq_any || ds_wake)
                    next_st = PMRC_RUN;
            PMRC_DEEP:
                if (ds_wake)
                    next_st = PMRC_WAIT_RC;
            PMRC_WAIT_RC:
                if (i_rc_osc_64m_stable)
                    next_st = PMRC_RUN;
            PMRC_STBY:
                if (sb_wake)
                    next_st = PMRC_RUN;
        endcase
    end

    // ****************************************
    // mode register
    // ****************************************
    // reset wins over all mode requests
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
            st <= PMRC_RUN;
        else
            st <= next_mode;
    end

    // ****************************************
    // reset stretch and clock gate
    // ****************************************
    pmrc_rst_sync u_rst (
        .i_clk_sys(i_clk_sys),
        .i_req(i_srst || rst_req),
        .o_rst(rst_out)
    );

    // the gate enable is registered once more, so the core clock comes on a cycle after the mode enters run
    assign gate_en_raw = core_runs(next_mode);
    pmrc_clk_gate u_gate (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_en(gate_en_raw),
        .o_en(gate_en)
    );

    // ****************************************
    // outputs
    // ****************************************
    // next output levels; the clock, power and retention ones decoded from the mode being entered
    assign next_core_clk = gate_en && core_runs(next_mode);
    assign next_periph = core_runs(next_mode) || (next_mode == PMRC_SLEEP);
    assign clk_tree_on = osc_alive(next_mode);
    assign core_powered = domain_powered(next_mode);
    assign next_retain = (next_mode == PMRC_DEEP) || (next_mode == PMRC_WAIT_RC);
    // single pulse on the edge that leaves deep-sleep, whatever source ran before
    assign next_force = (st == PMRC_DEEP) && (next_mode == PMRC_WAIT_RC);
    // rising edge only, so a supply that stays low does not flood software
    assign next_lvd_irq = i_low_voltage_detector && !lvd_q;
    // boot pin picks the word; past the top of the range it clamps rather than wraps
    assign boot_pick = i_boot_pin ? i_boot_address_values1 : i_boot_address_values0;
    assign next_boot_addr = (boot_pick > pmrc_pkg::BOOT_ADDR_MAX) ? pmrc_pkg::BOOT_ADDR_MAX
        : boot_pick;

    // clock and power enables; backup and debug are not outputs here, so untouched
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_core_clk_en <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_core_domain_clk_en <= 1'b1;
            o_low_power_rc_4m_en <= 1'b1;
            o_rc_osc_64m_en <= 1'b1;
            o_high_speed_crystal_en <= 1'b1;
            o_pll_en <= 1'b1;
            o_regulator_en <= 1'b1;
            o_core_domain_pwr <= 1'b1;
            o_retain <= 1'b0;
            o_clk_src_force <= 1'b0;
            o_clk_src <= pmrc_pkg::CLK_SRC_RC64M;
            o_mode <= 3'(PMRC_RUN);
        end
        else
        begin
            o_core_clk_en <= next_core_clk;
            o_periph_clk_en <= next_periph;
            o_core_domain_clk_en <= clk_tree_on;
            o_low_power_rc_4m_en <= clk_tree_on;
            o_rc_osc_64m_en <= clk_tree_on;
            o_high_speed_crystal_en <= clk_tree_on;
            o_pll_en <= clk_tree_on;
            o_regulator_en <= core_powered;
            o_core_domain_pwr <= core_powered;
            o_retain <= next_retain;
            o_clk_src_force <= next_force;
            o_clk_src <= pmrc_pkg::CLK_SRC_RC64M;
            o_mode <= 3'(next_mode);
        end
    end

    // reset and warning outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_sys_rst <= 1'b1;
            o_lvd_irq <= 1'b0;
            lvd_q <= 1'b0;
        end
        else
        begin
            o_sys_rst <= rst_out;
            o_lvd_irq <= next_lvd_irq;
            lvd_q <= i_low_voltage_detector;
        end
    end

    // boot choice is taken only while reset stands, so it never moves under running code
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_boot_addr <= 32'h0000_0000;
            o_boot_mode <= pmrc_pkg::BOOT_USER;
        end
        else if (rst_out)
        begin
            o_boot_mode <= i_boot_mode;
            o_boot_addr <= next_boot_addr;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_sleep_periph: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_SLEEP |-> o_periph_clk_en && !o_core_clk_en)
        else $error("sleep clocks wrong");
    a_sleep_wake: assert property (@(posedge i_clk_sys) disable iff (i_srst || rst_out)
        st == PMRC_SLEEP && i_irq_any |=> st == PMRC_RUN)
        else $error("sleep did not wake");
    a_deep_clk_off: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_DEEP && $past(st) == PMRC_DEEP |-> !o_pll_en && !o_rc_osc_64m_en)
        else $error("clocks on in deep-sleep");
    a_deep_osc_off: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_DEEP |-> !o_core_domain_clk_en && !o_high_speed_crystal_en
        && !o_low_power_rc_4m_en && !o_periph_clk_en)
        else $error("deep-sleep oscillators on");
    a_deep_retain: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_DEEP && $past(st) == PMRC_DEEP |-> o_retain)
        else $error("retention lost");
    a_deep_exit: assert property (@(posedge i_clk_sys) disable iff (i_srst || rst_out)
        st == PMRC_DEEP && ds_wake |=> st == PMRC_WAIT_RC)
        else $error("deep-sleep not left");
    a_rc_select: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_WAIT_RC && $past(st) == PMRC_DEEP
        |-> o_clk_src_force && o_clk_src == pmrc_pkg::CLK_SRC_RC64M)
        else $error("wrong clock source");
    a_stby_pwr: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_STBY && $past(st) == PMRC_STBY |-> !o_regulator_en)
        else $error("regulator on in standby");
    a_stby_osc_off: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_STBY |-> !o_rc_osc_64m_en && !o_low_power_rc_4m_en && !o_pll_en
        && !o_high_speed_crystal_en && !o_core_domain_pwr)
        else $error("standby supply or oscillators on");
    a_stby_restart: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_STBY && sb_wake |=> ##1 o_sys_rst)
        else $error("standby exit without reset");
    a_stby_exit: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_STBY && !sb_wake && !rst_out |=> st == PMRC_STBY)
        else $error("standby left without source");
    a_rst_to_run: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        rst_out |=> st == PMRC_RUN && o_mode == 3'(PMRC_RUN))
        else $error("reset left a low-power mode");
    a_supply_rst: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_supply_low |=> ##1 o_sys_rst)
        else $error("no reset on low supply");
    a_lvd_irq: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_low_voltage_detector && !lvd_q |=> o_lvd_irq)
        else $error("no low-voltage warning");
    a_lvd_single: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        o_lvd_irq |=> !o_lvd_irq)
        else $error("warning pulse too long");
    a_boot_pick: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        rst_out && !i_boot_pin && i_boot_address_values0 <= pmrc_pkg::BOOT_ADDR_MAX
        |=> o_boot_addr == $past(i_boot_address_values0))
        else $error("boot address not taken");
    a_rc_wait: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        st == PMRC_WAIT_RC |=> !o_core_clk_en || $past(i_rc_osc_64m_stable))
        else $error("core clock before RC stable");
endmodule

// File: hw/pmrc_pkg.sv
package pmrc_pkg;
    // power modes requested by the core
    typedef enum logic [1:0] {PMRC_REQ_SLEEP, PMRC_REQ_DEEP, PMRC_REQ_STBY, PMRC_REQ_NONE} pmrc_req_t;
    // boot choices
    localparam logic [1:0] BOOT_USER = 2'h0;
    localparam logic [1:0] BOOT_SECURITY = 2'h1;
    localparam logic [1:0] BOOT_SYSTEM = 2'h2;
    localparam logic [1:0] BOOT_SRAM = 2'h3;
    localparam logic [31:0] BOOT_ADDR_MAX = 32'h9000_0000;
    // system clock source codes
    localparam logic [1:0] CLK_SRC_RC64M = 2'h0;
    // wakeup source vector widths
    localparam int EXT_LINES = 16;
    localparam int DS_OTHER_SRC = 12;
    localparam int STBY_SRC = 5;
    // reset stretch after supervisor release
    localparam int RST_STRETCH_NS = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_STRETCH_CYC = (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RST_STRETCH_CNT = 4'(RST_STRETCH_CYC);
endpackage

// File: hw/pmrc_clk_gate.sv
`timescale 1ns/1ps
// glitch-free gate enable: changes only on the rising edge of i_clk_sys
module pmrc_clk_gate (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_en,
    output logic o_en
);
    // enable registered so downstream latch-free gating sees a clean edge
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
            o_en <= 1'b1;
        else
            o_en <= i_en;
    end
endmodule

// File: hw/pmrc_rst_sync.sv
`timescale 1ns/1ps
// stretches a reset request for a fixed number of cycles
module pmrc_rst_sync #(
    parameter logic [3:0] STRETCH = pmrc_pkg::RST_STRETCH_CNT
) (
    input wire logic i_clk_sys,
    input wire logic i_req,
    output logic o_rst
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    assign next_cnt = i_req ? STRETCH : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
    // held while the request stands, then counted down
    always_ff @(posedge i_clk_sys)
    begin
        cnt <= next_cnt;
        o_rst <= i_req || (cnt != 4'h0);
    end
endmodule

// File: bench/pmrc_rc_model.sv
`timescale 1ns/1ps
// ****************************************
// rc oscillator stand-in: settles some cycles after enable
// ****************************************
module pmrc_rc_model #(
    parameter int SETTLE = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_en,
    output logic o_stable
);
    int cnt = 0;
    // restart the settle count whenever the oscillator is switched off
    always @(posedge i_clk_sys)
    begin
        if (!i_en) cnt <= 0;
        else if (cnt < SETTLE) cnt <= cnt + 1;
    end
    assign o_stable = i_en && (cnt == SETTLE); // never ready while disabled
endmodule

// File: bench/tb_pmrc_top.sv
`timescale 1ns/1ps
module tb_pmrc_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic low_voltage_detector = 1'b0, sup = 1'b0, srq = 1'b0, bpin = 1'b0, stb;
    logic [2:0] rq = '0;
    logic [33:0] src = '0;
    logic [1:0] bmode = '0, bm_o, csrc;
    logic [31:0] ba0 = '0, ba1 = '0, ba_o, ea;
    logic [2:0] mode;
    logic core_en, per_en, cd_en, lp_en, rc_en, xt_en, pll_en, reg_en, pwr, ret, frc, rst_o, irq_o;
    logic [6:0] q[$];
    logic [6:0] e;
    logic [2:0] prev = '0;
    int fail_count = 0, checked = 0, n;
    // ****************************************
    // clock, design and partner
    // ****************************************
    // 100 mhz keeps the system, bus and peripheral domains under their ceilings
    initial forever #5 clk = ~clk;
    pmrc_top i_dut (.i_clk_sys(clk), .i_srst(srst), .i_sleep_req(rq[0]), .i_deep_req(rq[1]),
        .i_stby_req(rq[2]), .i_irq_any(src[0]), .i_ext_lines(src[16:1]),
        .i_ds_wake_src(src[28:17]), .i_external_reset_pin(src[29]), .i_rtc_wake(src[30]),
        .i_independent_watchdog(src[31]), .i_wakeup_pin(src[32]),
        .i_clock_monitor_lock_event(src[33]), .i_supply_low(sup), .i_low_voltage_detector(low_voltage_detector),
        .i_soft_reset(srq), .i_rc_osc_64m_stable(stb), .i_boot_pin(bpin), .i_boot_mode(bmode),
        .i_boot_address_values0(ba0), .i_boot_address_values1(ba1), .o_core_clk_en(core_en),
        .o_periph_clk_en(per_en), .o_core_domain_clk_en(cd_en), .o_low_power_rc_4m_en(lp_en),
        .o_rc_osc_64m_en(rc_en), .o_high_speed_crystal_en(xt_en), .o_pll_en(pll_en),
        .o_regulator_en(reg_en), .o_core_domain_pwr(pwr), .o_retain(ret),
        .o_clk_src_force(frc), .o_clk_src(csrc), .o_sys_rst(rst_o), .o_lvd_irq(irq_o),
        .o_boot_addr(ba_o), .o_boot_mode(bm_o), .o_mode(mode));
    pmrc_rc_model i_rc (.i_clk_sys(clk), .i_en(rc_en), .o_stable(stb));
    // ****************************************
    // helpers
    // ****************************************
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        checked++;
        if (sn !== ex)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // bounded wait; a run-out counts as a failure and ends the run
    task automatic wait_for(input logic [2:0] m, input logic r);
        int i;
        for (i = 0; i < 80 && (mode !== m || rst_o !== r); i++) @(negedge clk);
        if (mode !== m || rst_o !== r)
        begin
            cmp("wait_state", {m, r}, {mode, rst_o});
            summarize();
        end
    endtask
    task automatic go(input int k, input logic [6:0] ex);
        q.push_back(ex);
        @(posedge clk) rq[k] <= 1'b1;
        @(posedge clk) rq[k] <= 1'b0;
        wait_for(ex[6:4], 1'b0);
    endtask
    // hold a wake source until the mode moves, then drop it
    task automatic wake(input int b, input logic [6:0] ex);
        q.push_back(ex);
        @(posedge clk) src[b] <= 1'b1;
        wait_for(ex[6:4], rst_o);
        @(posedge clk) src[b] <= 1'b0;
    endtask
    // sources that must not move the mode: the monitor flags any change
    task automatic poke(input int b);
        @(posedge clk) src[b] <= 1'b1;
        repeat (3) @(posedge clk);
        src[b] <= 1'b0;
    endtask
    // ****************************************
    // monitor: every mode change takes the oldest note
    // ****************************************
    always @(negedge clk)
    begin
        if (!srst && mode !== prev)
        begin
            e = (q.size() > 0) ? q.pop_front() : 7'h7f;
            cmp("mode_state", e, {mode, rc_en, ret, reg_en, pwr});
            if (mode === 3'd3) cmp("exit_clk", {1'b1, pmrc_pkg::CLK_SRC_RC64M}, {frc, csrc});
            if (mode === 3'd3) cmp("core_gated", 0, core_en);
            prev = mode;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'hd1004b79));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        wait_for(3'd0, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            bpin <= 1'($urandom);
            bmode <= 2'(k);
            ba0 <= $urandom;
            ba1 <= (k == 3) ? 32'hffff_fff0 : $urandom;
            sup <= (k == 0);
            srq <= (k != 0);
            repeat ((k == 0) ? 20 : 3) @(posedge clk);
            @(negedge clk) cmp("held_in_reset", 1, rst_o);
            @(posedge clk);
            sup <= 1'b0;
            srq <= 1'b0;
            ea = bpin ? ba1 : ba0;
            if (ea > pmrc_pkg::BOOT_ADDR_MAX) ea = pmrc_pkg::BOOT_ADDR_MAX;
            wait_for(3'd0, 1'b0);
            cmp("boot_addr", ea, ba_o);
            cmp("boot_mode", k, bm_o);
        end
        go(0, {3'd1, 4'b1011});
        repeat (2) @(negedge clk);
        cmp("sleep_clocks", 2'b10, {per_en, core_en});
        wake(0, {3'd0, 4'b1011});
        for (int j = 1; j < 29; j++)
        begin
            go(1, {3'd2, 4'b0111});
            cmp("deep_off", 0, {cd_en, lp_en, xt_en, pll_en, per_en});
            if (j == 1) poke(0);
            wake(j, {3'd3, 4'b1111});
            q.push_back({3'd0, 4'b1011});
            wait_for(3'd0, 1'b0);
            @(negedge clk) cmp("core_back", 1, core_en);
        end
        for (int k = 0; k < 5; k++)
        begin
            go(2, {3'd4, 4'b0000});
            cmp("stby_off", 0, {cd_en, lp_en, xt_en, pll_en, per_en});
            poke(0);
            poke(1 + k);
            wake(29 + k, {3'd0, 4'b1011});
            @(negedge clk) cmp("stby_restart", 1, rst_o);
            wait_for(3'd0, 1'b0);
        end
        @(posedge clk) low_voltage_detector <= 1'b1;
        n = 0;
        repeat (8) @(negedge clk) n += int'(irq_o === 1'b1);
        cmp("lvd_pulse", 1, n);
        cmp("notes_left", 0, q.size());
        summarize();
    end
endmodule
